// File: rmtr_pkg.sv
// package for the regulator mode and transition register bank
package rmtr_pkg;
  // register addresses
  localparam logic [7:0] RMTR_ADDR_MODE_SRC  = 8'h02;
  localparam logic [7:0] RMTR_ADDR_TRANS_DIS = 8'h03;
  // mode_source_config field positions
  localparam int RMTR_MS_LOW_MODE_BIT  = 0;
  localparam int RMTR_MS_HIGH_MODE_BIT = 1;
  localparam int RMTR_MS_OVR_LSB       = 2;
  localparam int RMTR_MS_SRC_SEL_BIT   = 4;
  localparam int RMTR_MS_RSVD5_BIT     = 5;
  // transition_discharge_control field positions
  localparam int RMTR_TD_SLEW_LSB      = 0;
  localparam int RMTR_TD_INREG_BIT     = 5;
  localparam int RMTR_TD_PULLDOWN_BIT  = 6;
  localparam int RMTR_TD_TRIGGER_BIT   = 7;
  // override codes
  localparam logic [1:0] RMTR_OVR_DEFER  = 2'h0;
  localparam logic [1:0] RMTR_OVR_FORCED = 2'h2;
  // values after reset
  localparam logic [1:0] RMTR_RST_OVR      = 2'h0;
  localparam logic       RMTR_RST_SRC_SEL  = 1'b0;
  localparam logic       RMTR_RST_LOW_MODE = 1'b0;
  localparam logic       RMTR_RST_HI_MODE  = 1'b0;
  localparam logic       RMTR_RST_RSVD5    = 1'b1;
  localparam logic       RMTR_RST_PULLDOWN = 1'b1;
  localparam logic [2:0] RMTR_RST_SLEW     = 3'h0;
  // stages of the pin synchroniser
  localparam int RMTR_SYNC_STAGES = 3;

  // writable state of both registers
  typedef struct packed {
    logic       trigger;
    logic       pulldown_en;
    logic [2:0] slew;
    logic       src_sel;
    logic [1:0] ovr;
    logic       high_mode;
    logic       low_mode;
  } rmtr_regs_s;

  // pins from the analog side, synchronised as one group
  typedef struct packed {
    logic volt_select;
    logic reg_enabled;
    logic in_reg;
    logic cur_limit;
  } rmtr_pins_s;

  // slew step multiple of 0.15 mV/us for rising transitions
  function automatic logic [5:0] rmtr_slew_mult(input logic [2:0] code);
    case (code)
      3'h0:    rmtr_slew_mult = 6'h01;
      3'h1:    rmtr_slew_mult = 6'h02;
      3'h2:    rmtr_slew_mult = 6'h04;
      3'h3:    rmtr_slew_mult = 6'h08;
      3'h4:    rmtr_slew_mult = 6'h10;
      3'h5:    rmtr_slew_mult = 6'h20;
      default: rmtr_slew_mult = 6'h20;
    endcase
  endfunction
endpackage

// File: rmtr_regs.sv
// register bank for regulator mode selection, output transitions and discharge
// How it works
// - override 00 defers to the per-source bits, 10 forces fixed frequency, 01 and 11 allow light-load mode.
// - when deferring, the high-select mode bit picks the mode while the high select setting governs the output.
// - when deferring, the low-select mode bit picks the mode while the select input is low.
// - writing one to the trigger starts a transition when the source select bit is zero.
// - the trigger bit clears itself once the started transition completes.
// - the output pull-down is on only when its enable is set and the regulator is disabled.
// - the in-regulation flag reads one in regulation and zero when out of regulation or in current limit.
// - a three-bit slew field sets the ramp rate for rising transitions only.
// - slew codes 000 to 101 give 0.15 to 4.80 mV/us, doubling per step.
// - the mode and source select register answers at address 02.
// - the trigger, discharge, flag and slew register answers at address 03.
`timescale 1ns/1ps
module rmtr_regs
  import rmtr_pkg::*;
#(
  parameter int SYNC_STAGES = RMTR_SYNC_STAGES  // flip-flops on each pin
)
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       voltage_select_input,
  input  wire logic       regulator_enabled,
  input  wire logic       output_in_reg,
  input  wire logic       current_limit,
  input  wire logic       transition_done,
  output logic            transition_start,
  output logic            forced_fixed_freq,
  output logic            high_select_active,
  output logic            off_pulldown_on,
  output logic      [2:0] rise_slew_code,
  output logic      [5:0] rise_slew_mult,
  output logic            in_regulation_flag
);
  import rmtr_pkg::*;

  // refuse settings the fixed logic cannot serve
  if (SYNC_STAGES != 3) begin : g_bad_sync
    $error("rmtr_regs: only a three-stage pin synchroniser is built");
  end
  if (RMTR_MS_OVR_LSB + 2 > RMTR_MS_SRC_SEL_BIT) begin : g_bad_ovr
    $error("rmtr_regs: override field overlaps the source select bit");
  end
  if (RMTR_TD_SLEW_LSB + 3 > RMTR_TD_INREG_BIT) begin : g_bad_slew
    $error("rmtr_regs: slew field overlaps the in-regulation bit");
  end

  rmtr_regs_s regs_q, regs_d;
  rmtr_pins_s pins_raw;
  rmtr_pins_s sync1_q, sync2_q, sync3_q, pins_q;
  rmtr_pins_s pins_d;
  logic [7:0] rdata_q, rdata_d;
  logic       start_q, start_d;
  logic [7:0] mode_src_val;
  logic [7:0] trans_val;
  logic       wr_mode_src;
  logic       wr_trans;
  logic       trig_accept;
  logic [1:0] hit;

  // pins gathered into one group
  assign pins_raw = '{volt_select: voltage_select_input,
                      reg_enabled: regulator_enabled,
                      in_reg:      output_in_reg,
                      cur_limit:   current_limit};

  // filtered pins follow once stages two and three agree
  always_comb begin
    pins_d = pins_q;
    for (int i = 0; i < $bits(rmtr_pins_s); i++) begin
      if (sync2_q[i] == sync3_q[i]) begin
        pins_d[i] = sync3_q[i];
      end
    end
  end

  // three-stage synchroniser and filtered pin state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pins_q  <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q  <= pins_d;
    end
  end

  // one-hot hit of the two mapped addresses
  function automatic logic [1:0] addr_hit(input logic [7:0] addr);
    addr_hit    = 2'h0;
    addr_hit[0] = (addr == RMTR_ADDR_MODE_SRC);
    addr_hit[1] = (addr == RMTR_ADDR_TRANS_DIS);
  endfunction

  // address decode of the two registers
  assign hit         = addr_hit(reg_addr);
  assign wr_mode_src = reg_wr && hit[0];
  assign wr_trans    = reg_wr && hit[1];
  assign trig_accept = wr_trans && reg_wdata[RMTR_TD_TRIGGER_BIT] && !regs_q.src_sel;

  // register writes, trigger set and self clear
  always_comb begin
    regs_d  = regs_q;
    start_d = 1'b0;
    if (wr_mode_src) begin
      regs_d.low_mode  = reg_wdata[RMTR_MS_LOW_MODE_BIT];
      regs_d.high_mode = reg_wdata[RMTR_MS_HIGH_MODE_BIT];
      regs_d.ovr       = reg_wdata[RMTR_MS_OVR_LSB +: 2];
      regs_d.src_sel   = reg_wdata[RMTR_MS_SRC_SEL_BIT];
    end
    if (wr_trans) begin
      regs_d.pulldown_en = reg_wdata[RMTR_TD_PULLDOWN_BIT];
      regs_d.slew        = reg_wdata[RMTR_TD_SLEW_LSB +: 3];
    end
    if (transition_done) begin
      regs_d.trigger = 1'b0;
    end
    if (trig_accept) begin
      regs_d.trigger = 1'b1;                               // set wins over clear
      start_d        = 1'b1;
    end
  end

  // register state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regs_q <= '{trigger:     1'b0,
                  pulldown_en: RMTR_RST_PULLDOWN,
                  slew:        RMTR_RST_SLEW,
                  src_sel:     RMTR_RST_SRC_SEL,
                  ovr:         RMTR_RST_OVR,
                  high_mode:   RMTR_RST_HI_MODE,
                  low_mode:    RMTR_RST_LOW_MODE};
      start_q <= 1'b0;
    end else begin
      regs_q  <= regs_d;
      start_q <= start_d;
    end
  end

  // read values; reserved bits show their reset values
  always_comb begin
    mode_src_val                                = 8'h00;
    mode_src_val[RMTR_MS_LOW_MODE_BIT]          = regs_q.low_mode;
    mode_src_val[RMTR_MS_HIGH_MODE_BIT]         = regs_q.high_mode;
    mode_src_val[RMTR_MS_OVR_LSB +: 2]          = regs_q.ovr;
    mode_src_val[RMTR_MS_SRC_SEL_BIT]           = regs_q.src_sel;
    mode_src_val[RMTR_MS_RSVD5_BIT]             = RMTR_RST_RSVD5;
    trans_val                                   = 8'h00;
    trans_val[RMTR_TD_SLEW_LSB +: 3]            = regs_q.slew;
    trans_val[RMTR_TD_INREG_BIT]                = in_regulation_flag;
    trans_val[RMTR_TD_PULLDOWN_BIT]             = regs_q.pulldown_en;
    trans_val[RMTR_TD_TRIGGER_BIT]              = regs_q.trigger;
  end

  // registered read data, zero for other addresses
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (hit)
        2'h1:    rdata_d = mode_src_val;
        2'h2:    rdata_d = trans_val;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // mode selection
  always_comb begin
    high_select_active = pins_q.volt_select;
    if (regs_q.ovr == RMTR_OVR_DEFER) begin
      forced_fixed_freq = pins_q.volt_select ? regs_q.high_mode
                                             : regs_q.low_mode;
    end else begin
      forced_fixed_freq = (regs_q.ovr == RMTR_OVR_FORCED);
    end
  end

  // outputs to the analog side
  assign off_pulldown_on    = regs_q.pulldown_en && !pins_q.reg_enabled;
  assign in_regulation_flag = pins_q.in_reg && !pins_q.cur_limit;
  assign rise_slew_code     = regs_q.slew;
  assign rise_slew_mult     = rmtr_slew_mult(regs_q.slew);
  assign transition_start   = start_q;
  assign reg_rdata          = rdata_q;
endmodule // rmtr_regs

// File: rmtr_regs_chk.sv
// assertions watching the regulator register bank ports
`timescale 1ns/1ps
module rmtr_regs_chk (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       transition_start,
  input wire logic       forced_fixed_freq,
  input wire logic       off_pulldown_on,
  input wire logic [2:0] rise_slew_code,
  input wire logic [5:0] rise_slew_mult
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // decoded write strobes
  wire w2 = reg_wr && reg_addr == 8'h02;
  wire w3 = reg_wr && reg_addr == 8'h03;
  chk_go_start: assert property (transition_start |-> $past(w3 && reg_wdata[7]))
    else $error("start without trigger write");
  chk_ovr_forced: assert property (w2 && reg_wdata[3:2] == 2'h2 |=> forced_fixed_freq)
    else $error("override 10 not forced");
  chk_ovr_auto: assert property (w2 && reg_wdata[2] |=> !forced_fixed_freq)
    else $error("override 01 or 11 not automatic");
  chk_pd_clear: assert property (w3 && !reg_wdata[6] |=> !off_pulldown_on)
    else $error("pull-down on with enable clear");
  chk_slew_wr: assert property (w3 |=> rise_slew_code == $past(reg_wdata[2:0]))
    else $error("slew field not stored");
  chk_slew_map: assert property (rise_slew_mult ==
    (rise_slew_code > 3'h5 ? 6'h20 : 6'h01 << rise_slew_code)) else $error("slew multiple wrong");
  chk_rd_unmap: assert property (reg_rd && reg_addr > 8'h03 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rd_rsvd: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata[7:5] == 3'h1)
    else $error("reserved bits of mode register wrong");
  cov_start: cover property (transition_start);
  cov_forced: cover property (forced_fixed_freq);
  cov_unmap: cover property (reg_rd && reg_addr == 8'h04);
endmodule // rmtr_regs_chk
bind rmtr_regs rmtr_regs_chk u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transition_start(transition_start),
  .forced_fixed_freq(forced_fixed_freq), .off_pulldown_on(off_pulldown_on),
  .rise_slew_code(rise_slew_code), .rise_slew_mult(rise_slew_mult)
);

// File: rmtr_slew_model.sv
// slew engine model: reports completion a set number of cycles after a start
`timescale 1ns/1ps
module rmtr_slew_model (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       transition_start,
  input  wire logic [7:0] ramp_len,
  output logic            transition_done
);
  logic [7:0] cnt_q;
  // ramp countdown, restarted by each start
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= 8'h00;
    else if (transition_start) cnt_q <= ramp_len;
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end
  assign transition_done = (cnt_q == 8'h01);
endmodule // rmtr_slew_model

// File: rmtr_regs_bench.sv
// self-checking bench for the regulator register bank
`timescale 1ns/1ps
module rmtr_regs_bench;
  import rmtr_pkg::*;
  logic       sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ramp = 8'h14;
  rmtr_pins_s pin = '0;
  logic       done, start, ffix, hsel, pd_on, flag;
  logic [2:0] code;
  logic [5:0] mult;
  int         mismatches = 0, num_checks = 0, starts = 0;
  rmtr_regs dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .voltage_select_input(pin.volt_select), .regulator_enabled(pin.reg_enabled),
    .output_in_reg(pin.in_reg), .current_limit(pin.cur_limit), .transition_done(done),
    .transition_start(start), .forced_fixed_freq(ffix), .high_select_active(hsel),
    .off_pulldown_on(pd_on), .rise_slew_code(code), .rise_slew_mult(mult), .in_regulation_flag(flag));
  rmtr_slew_model u_eng (.sys_clk(sys_clk), .arst_n(arst_n), .transition_start(start),
    .ramp_len(ramp), .transition_done(done));
  // clock and start-pulse count
  initial forever #50 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (start === 1'b1) starts++;
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
    cmp("read data", e, reg_rdata);
  endtask
  // expected mode from override, mode bits and select level
  function automatic logic fexp(input logic [7:0] d, input logic v);
    return d[3:2] == 2'h2 || (d[3:2] == 2'h0 && (v ? d[1] : d[0]));
  endfunction
  function automatic logic [7:0] mexp(input logic [2:0] c);
    return c > 3'h5 ? 8'h20 : 8'h01 << c;
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog well past the expected run length
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end
  // main sequence
  initial begin
    int i;
    logic [7:0] d;
    void'($urandom(32'heed8d2f9));
    cyc(10);
    arst_n = 1'b1;
    rd(8'h02, 8'h20);
    rd(8'h03, 8'h40);
    for (i = 0; i < 16; i++) begin
      d = 8'($urandom);
      d[4:2] = {1'b0, i[1:0]};
      pin.volt_select = 1'($urandom);
      wr(8'h02, d);
      cyc(6);
      cmp("fixed freq", {7'h0, fexp(d, pin.volt_select)}, {7'h0, ffix});
      cmp("high select", {7'h0, pin.volt_select}, {7'h0, hsel});
      rd(8'h02, {3'h1, d[4:0]});
    end
    for (i = 0; i < 8; i++) begin
      wr(8'h03, {5'h0f, i[2:0]});
      cmp("slew mult", mexp(i[2:0]), {2'h0, mult});
      cmp("slew code", {5'h00, i[2:0]}, {5'h00, code});
      rd(8'h03, {5'h08, i[2:0]});
    end
    wr(8'h03, 8'h80);
    rd(8'h03, 8'h80);
    cmp("starts", 8'h01, 8'(starts));
    cyc(24);
    rd(8'h03, 8'h00);
    ramp = 8'h01;
    wr(8'h03, 8'h80);
    cyc(2);
    rd(8'h03, 8'h00);
    wr(8'h02, 8'h10);
    wr(8'h03, 8'h80);
    rd(8'h03, 8'h00);
    cmp("starts", 8'h02, 8'(starts));
    for (i = 0; i < 8; i++) begin
      pin[2:0] = i[2:0];
      d = 8'($urandom) & 8'h47;
      wr(8'h03, d);
      cyc(6);
      cmp("flag", {7'h0, i[1] & !i[0]}, {7'h0, flag});
      cmp("pull-down", {7'h0, d[6] & !i[2]}, {7'h0, pd_on});
      rd(8'h03, {1'b0, d[6], i[1] & !i[0], d[4:0]});
    end
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h00);
    rd(8'h02, 8'h30);
    // new trigger write in the cycle the engine reports done: set wins
    wr(8'h02, 8'h00);
    ramp = 8'h03;
    wr(8'h03, 8'h80);
    cyc(2);
    wr(8'h03, 8'h80);
    rd(8'h03, 8'h80);
    cmp("starts", 8'h04, 8'(starts));
    give_verdict();
  end
endmodule // rmtr_regs_bench
